// ===== fsr_host_model.sv
// host controller model: single-read strobes on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
    input wire logic clk,
    input wire logic dq_oe,
    input wire logic [15:0] dq_out,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic [20:0] addr
);
    initial begin
        chip_enable_n = 1'b1;
        output_enable_n = 1'b1;
        addr = 21'h000000;
    end
    // single reads only: a burst would keep the first status snapshot of its strobe
    task automatic rd_begin(input logic [20:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        addr = a;
        chip_enable_n = 1'b0;
        output_enable_n = 1'b0;
        n = 0;
        while (dq_oe !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        d = dq_out;
    endtask
    task automatic rd_end();
        @(negedge clk);
        chip_enable_n = 1'b1;
        output_enable_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // only the idle flag is trusted until it reads 1
    task automatic poll_idle(input logic [20:0] a, output logic [15:0] d);
        int n;
        n = 0;
        d = 16'h0000;
        while (d[7] !== 1'b1 && n < 8) begin
            rd_begin(a, d);
            rd_end();
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ===== fsr_pkg.sv
// package: status word layout, states and reset values for status reporting
package fsr_pkg;

    localparam int FSR_DATA_W = 16;
    localparam int FSR_STATUS_W = 8;
    localparam int FSR_SYNC_STAGES = 2;

    // bit positions inside the status word
    localparam int FSR_BIT_IDLE = 7;
    localparam int FSR_BIT_ERASE_SUSP = 6;
    localparam int FSR_BIT_ERASE_FAIL = 5;
    localparam int FSR_BIT_PROG_FAIL = 4;
    localparam int FSR_BIT_SUPPLY = 3;
    localparam int FSR_BIT_PROG_SUSP = 2;
    localparam int FSR_BIT_LOCKED = 1;
    localparam int FSR_BIT_BANK_BUSY = 0;

    localparam logic [FSR_STATUS_W-1:0] FSR_STATUS_RST = 8'h80;
    localparam logic [FSR_DATA_W-1:0] FSR_DATA_RST = 16'h0000;
    localparam logic [FSR_DATA_W-FSR_STATUS_W-1:0] FSR_UPPER_ZERO = 8'h00;

    typedef struct packed {
        logic engine_idle_flag;
        logic erase_suspended_flag;
        logic erase_fail_flag;
        logic program_fail_flag;
        logic supply_fault_flag;
        logic program_suspended_flag;
        logic locked_block_flag;
        logic bank_busy_flag;
    } fsr_status_t;

    // events from the program/erase engine, all one-cycle pulses
    typedef struct packed {
        logic op_start;
        logic op_is_erase;
        logic op_block_locked;
        logic op_done;
        logic erase_verify_fail;
        logic program_verify_fail;
        logic overprogram_attempt;
        logic suspend_cmd;
        logic resume_cmd;
        logic engine_paused;
        logic clear_status_cmd;
        logic read_status_cmd;
        logic read_array_cmd;
    } fsr_engine_ev_t;

    typedef enum logic [3:0] {
        FSR_ST_IDLE = 4'b0001,
        FSR_ST_RUN = 4'b0010,
        FSR_ST_SUSP_PEND = 4'b0100,
        FSR_ST_SUSPENDED = 4'b1000
    } fsr_state_t;

endpackage

// ===== fsr_status_chk.sv
// assertion checker for the status unit ports
`timescale 1ns/1ps
`default_nettype none
module fsr_status_chk
    import fsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire fsr_engine_ev_t engine_ev,
    input wire logic op_go,
    input wire logic op_abort,
    input wire logic engine_suspend_req,
    input wire logic dq_oe,
    input wire fsr_status_t live_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [3:0] errs = {live_status[5:3], live_status[1]};
    wire logic strb = !chip_enable_n && !output_enable_n;
    wire logic idle = live_status.engine_idle_flag;
    wire logic susp = live_status[6] || live_status[2];
    ////////////////////////////////////////////////////////////
    sequence s_susp;
        engine_ev.suspend_cmd && !idle;
    endsequence
    sequence s_pause;
        engine_suspend_req && engine_ev.engine_paused;
    endsequence
    a_lock_abort: assert property (
        engine_ev.op_start && engine_ev.op_block_locked
        |-> op_abort && !op_go ##1 live_status.locked_block_flag)
        else $error("locked start not refused");
    a_go_busy: assert property (
        op_go |=> !idle)
        else $error("idle after start");
    a_done_idle: assert property (
        engine_ev.op_done && !idle |=> idle)
        else $error("busy after done");
    a_err_sticky: assert property (
        !engine_ev.clear_status_cmd
        |=> (errs & $past(errs)) == $past(errs))
        else $error("error flag lost");
    a_err_clear: assert property (
        engine_ev.clear_status_cmd && !engine_ev.op_start
        && !engine_ev.erase_verify_fail && !engine_ev.program_verify_fail
        && !engine_ev.overprogram_attempt |=> errs == 4'h0)
        else $error("clear ignored");
    a_susp_pend: assert property (
        s_susp |=> engine_suspend_req && !idle)
        else $error("suspend not pending");
    a_pend_wait: assert property (
        engine_suspend_req && !engine_ev.engine_paused
        && !engine_ev.op_done |=> !idle)
        else $error("idle before pause");
    a_pause_idle: assert property (
        s_pause |=> idle && (live_status[6] ^ live_status[2]))
        else $error("pause not shown");
    a_resume_clr: assert property (
        engine_ev.resume_cmd && susp |=> !susp && !idle)
        else $error("resume kept flag");
    a_strobe_oe: assert property (
        strb [*4] |-> dq_oe)
        else $error("no drive on read");
endmodule
bind fsr_status_unit fsr_status_chk u_chk (.clk, .rst, .chip_enable_n,
    .output_enable_n, .engine_ev, .op_go, .op_abort, .engine_suspend_req,
    .dq_oe, .live_status);
`default_nettype wire

// ===== fsr_status_unit.sv
// status word tracking, capture and bus drive for the flash status logic
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - capture status on strobe falling edge, hold it until strobe rises
// - reads inside the busy bank return status during program or erase
// - idle, suspend and bank busy flags follow engine state by themselves
// - error flags are sticky until clear-status command or reset
// - bit 0 is per addressed bank; other bits device-wide
// - idle flag 0 while engine active, 1 when inactive and ready
// - after suspend, idle stays 0 until engine actually pauses
// - erase-suspended set once erase paused; near-done erase may finish
// - resume after erase suspension clears erase-suspended flag
// - erase-fail set when max pulses applied and verify still fails
// - stale error stays set, so the next command appears failed
// - program-fail set when max pulses applied and verify still fails
// - overprogram attempt sets program-fail only at high supply level
// - supply validity sampled only at start of each operation
// - low supply sample sets supply-fault and aborts the operation
// - program-suspended set once program paused; near-done may finish
// - resume after program suspension clears program-suspended flag
// - operation on locked block sets locked-block flag and aborts
// - busy bit 0 for addressed busy bank, 1 when another bank busy
// - factory mode: bit 0 is 0 when next word accepted, 1 otherwise
module fsr_status_unit
    import fsr_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int BANK_W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic supply_above_lockout,
    input wire logic supply_at_high_level,
    input wire fsr_engine_ev_t engine_ev,
    input wire logic [BANK_W-1:0] op_bank,
    input wire logic factory_bulk_program_mode,
    input wire logic factory_word_ready,
    input wire logic [FSR_DATA_W-1:0] array_data,
    output logic op_go,
    output logic op_abort,
    output logic engine_suspend_req,
    output logic [FSR_DATA_W-1:0] dq_out,
    output logic dq_oe,
    output fsr_status_t live_status
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic ce_n_s;
    logic oe_n_s;
    logic supply_ok_s;
    logic supply_high_s;
    logic [ADDR_W-1:0] addr_s;

    fsr_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_strobe (
        .clk(clk),
        .rst(rst),
        .d({chip_enable_n, output_enable_n}),
        .q({ce_n_s, oe_n_s})
    );

    fsr_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_supply (
        .clk(clk),
        .rst(rst),
        .d({supply_above_lockout, supply_at_high_level}),
        .q({supply_ok_s, supply_high_s})
    );

    // same latency as the strobes, so the captured bank matches the read
    fsr_sync #(.WIDTH(ADDR_W), .RST_VAL('0)) u_sync_addr (
        .clk(clk),
        .rst(rst),
        .d(addr),
        .q(addr_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // engine state

    fsr_state_t state_reg;
    fsr_state_t state_next;
    logic op_erase_reg;
    logic [BANK_W-1:0] busy_bank_reg;
    logic start_ok;

    // supply validity looked at only with op_start, never during the operation
    assign start_ok = engine_ev.op_start && supply_ok_s
        && !engine_ev.op_block_locked;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FSR_ST_IDLE: begin
                if (start_ok) begin
                    state_next = FSR_ST_RUN;
                end
            end
            FSR_ST_RUN: begin
                if (engine_ev.op_done) begin
                    state_next = FSR_ST_IDLE;
                end else if (engine_ev.suspend_cmd) begin
                    state_next = FSR_ST_SUSP_PEND;
                end
            end
            FSR_ST_SUSP_PEND: begin
                // near-done operation may finish instead of pausing
                if (engine_ev.op_done) begin
                    state_next = FSR_ST_IDLE;
                end else if (engine_ev.engine_paused) begin
                    state_next = FSR_ST_SUSPENDED;
                end
            end
            FSR_ST_SUSPENDED: begin
                if (engine_ev.resume_cmd) begin
                    state_next = FSR_ST_RUN;
                end
            end
            default: begin
                state_next = FSR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= FSR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_erase_reg <= 1'b0;
            busy_bank_reg <= '0;
        end else if (start_ok && state_reg == FSR_ST_IDLE) begin
            op_erase_reg <= engine_ev.op_is_erase;
            busy_bank_reg <= op_bank;
        end
    end

    assign op_go = start_ok && state_reg == FSR_ST_IDLE;
    assign op_abort = engine_ev.op_start && !start_ok;
    assign engine_suspend_req = state_reg == FSR_ST_SUSP_PEND;

    ////////////////////////////////////////////////////////////////////////
    // sticky error flags: a set in the clear cycle wins

    logic erase_fail_reg;
    logic program_fail_reg;
    logic supply_fault_reg;
    logic locked_block_reg;
    logic set_erase_fail;
    logic set_program_fail;
    logic set_supply_fault;
    logic set_locked_block;

    assign set_erase_fail = engine_ev.erase_verify_fail;
    assign set_program_fail = engine_ev.program_verify_fail
        || (engine_ev.overprogram_attempt && supply_high_s);
    assign set_supply_fault = engine_ev.op_start && !supply_ok_s;
    assign set_locked_block = engine_ev.op_start
        && engine_ev.op_block_locked;

    // no clear on a new command: stale error survives it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_fail_reg <= 1'b0;
        end else begin
            erase_fail_reg <= set_erase_fail
                || (erase_fail_reg && !engine_ev.clear_status_cmd);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            program_fail_reg <= 1'b0;
        end else begin
            program_fail_reg <= set_program_fail
                || (program_fail_reg && !engine_ev.clear_status_cmd);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_fault_reg <= 1'b0;
        end else begin
            supply_fault_reg <= set_supply_fault
                || (supply_fault_reg && !engine_ev.clear_status_cmd);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            locked_block_reg <= 1'b0;
        end else begin
            locked_block_reg <= set_locked_block
                || (locked_block_reg && !engine_ev.clear_status_cmd);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live status word

    logic engine_active;
    logic addr_in_busy_bank;

    assign engine_active = state_reg == FSR_ST_RUN
        || state_reg == FSR_ST_SUSP_PEND;
    assign addr_in_busy_bank =
        addr_s[ADDR_W-1 -: BANK_W] == busy_bank_reg;

    always_comb begin
        live_status.engine_idle_flag = !engine_active;
        live_status.erase_suspended_flag = state_reg == FSR_ST_SUSPENDED
            && op_erase_reg;
        live_status.erase_fail_flag = erase_fail_reg;
        live_status.program_fail_flag = program_fail_reg;
        live_status.supply_fault_flag = supply_fault_reg;
        live_status.program_suspended_flag = state_reg == FSR_ST_SUSPENDED
            && !op_erase_reg;
        live_status.locked_block_flag = locked_block_reg;
        // bit 0 has no meaning while idle, so outside factory mode it is held low there
        if (factory_bulk_program_mode) begin
            live_status.bank_busy_flag = !factory_word_ready;
        end else if (engine_active) begin
            live_status.bank_busy_flag = !addr_in_busy_bank;
        end else begin
            live_status.bank_busy_flag = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mode and bus drive

    logic status_mode_reg;
    logic read_active;
    logic read_active_d_reg;
    logic status_select;
    logic [FSR_STATUS_W-1:0] captured_reg;
    logic capture_status_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_mode_reg <= 1'b0;
        // status mode survives operations until a read-array command
        end else if (engine_ev.read_status_cmd) begin
            status_mode_reg <= 1'b1;
        end else if (engine_ev.read_array_cmd) begin
            status_mode_reg <= 1'b0;
        end
    end

    assign read_active = !ce_n_s && !oe_n_s;
    // the busy bank answers with status whatever read mode was chosen
    assign status_select = status_mode_reg
        || (engine_active && addr_in_busy_bank);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_active_d_reg <= 1'b0;
        end else begin
            read_active_d_reg <= read_active;
        end
    end

    // one snapshot per strobe, so single reads only see fresh data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            captured_reg <= FSR_STATUS_RST;
            capture_status_reg <= 1'b0;
        end else if (read_active && !read_active_d_reg) begin
            captured_reg <= live_status;
            capture_status_reg <= status_select;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_out <= FSR_DATA_RST;
        end else if (capture_status_reg) begin
            dq_out <= {FSR_UPPER_ZERO, captured_reg};
        end else begin
            dq_out <= array_data;
        end
    end

    // limitation: the synchronisers add two clocks before data can appear
    assign dq_oe = read_active && read_active_d_reg;

endmodule
`default_nettype wire

// ===== fsr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fsr_sync
    import fsr_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // first stage read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the status unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fsr_pkg::*;
;
    logic clk, rst, supply_above_lockout, supply_at_high_level;
    logic factory_bulk_program_mode, factory_word_ready, op_go, op_abort;
    logic chip_enable_n, output_enable_n, engine_suspend_req, dq_oe;
    logic [20:0] addr;
    logic [2:0] op_bank;
    logic [1:0] ga;
    logic [15:0] array_data, dq_out, d;
    fsr_engine_ev_t engine_ev;
    fsr_status_t live_status;
    int fail_count = 0, num_checks = 0, cyc = 0;
    fsr_status_unit dut (.clk, .rst, .chip_enable_n, .output_enable_n, .addr,
        .supply_above_lockout, .supply_at_high_level, .engine_ev, .op_bank,
        .factory_bulk_program_mode, .factory_word_ready, .array_data, .op_go,
        .op_abort, .engine_suspend_req, .dq_out, .dq_oe, .live_status);
    fsr_host_model host (.clk, .dq_oe, .dq_out, .chip_enable_n,
        .output_enable_n, .addr);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, exp, input string w);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // masks follow the event struct order, op_start at bit 12
    task automatic ev(input logic [12:0] m);
        @(negedge clk);
        engine_ev = fsr_engine_ev_t'(m);
        #1 ga = {op_go, op_abort};
        @(negedge clk);
        engine_ev = '0;
    endtask
    task automatic rd(input logic [20:0] a);
        host.rd_begin(a, d);
        host.rd_end();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        engine_ev = '0;
        op_bank = 3'h2;
        supply_above_lockout = 1'b1;
        supply_at_high_level = 1'b1;
        factory_bulk_program_mode = 1'b0;
        factory_word_ready = 1'b0;
        array_data = 16'h5a3c;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(live_status, 8'h80, "reset");
        ev(13'h0002);
        rd(21'h000000);
        chk(d, 16'h0080, "rd idle");
        ev(13'h0001);
        ev(13'h1000);
        chk(ga, 2'b10, "go");
        chk(live_status, 8'h01, "other bank");
        rd(21'h080000);
        chk(d, 16'h0000, "busy bank rd");
        chk(live_status, 8'h00, "own bank");
        rd(21'h040000);
        chk(d, 16'h5a3c, "array rd");
        factory_bulk_program_mode = 1'b1;
        repeat (3) @(negedge clk);
        chk(live_status[0], 1'b1, "efp wait");
        factory_word_ready = 1'b1;
        repeat (3) @(negedge clk);
        chk(live_status[0], 1'b0, "efp ready");
        factory_bulk_program_mode = 1'b0;
        ev(13'h0080);
        ev(13'h0200);
        chk(live_status, 8'h90, "pfail");
        ev(13'h1000);
        ev(13'h0200);
        chk(live_status, 8'h90, "stale");
        ev(13'h0004);
        chk(live_status, 8'h80, "clear");
        ev(13'h1800);
        ev(13'h0100);
        ev(13'h0200);
        chk(live_status, 8'ha0, "efail");
        ev(13'h1400);
        chk(ga, 2'b01, "lock abort");
        chk(live_status, 8'ha2, "lock");
        ev(13'h0004);
        ev(13'h1000);
        supply_above_lockout = 1'b0;
        repeat (4) @(negedge clk);
        ev(13'h0200);
        chk(live_status, 8'h80, "mid supply");
        ev(13'h1000);
        chk(ga, 2'b01, "low abort");
        chk(live_status, 8'h88, "low supply");
        supply_above_lockout = 1'b1;
        repeat (3) @(negedge clk);
        ev(13'h1000);
        chk(ga, 2'b10, "ok supply");
        supply_at_high_level = 1'b0;
        repeat (4) @(negedge clk);
        ev(13'h0040);
        chk(live_status, 8'h09, "over low");
        ev(13'h0004);
        supply_at_high_level = 1'b1;
        repeat (4) @(negedge clk);
        ev(13'h0040);
        ev(13'h0200);
        chk(live_status, 8'h90, "over high");
        ev(13'h0004);
        for (int k = 0; k < 2; k++) begin
            ev(k ? 13'h1000 : 13'h1800);
            ev(13'h0020);
            chk(engine_suspend_req, 1'b1, "pend");
            chk(live_status, 8'h01, "pend st");
            ev(13'h0008);
            chk(live_status, k ? 8'h84 : 8'hc0, "susp");
            ev(13'h0010);
            chk(live_status, 8'h01, "resume");
            ev(13'h0200);
        end
        ev(13'h1800);
        ev(13'h0020);
        ev(13'h0200);
        chk(live_status, 8'h80, "near done");
        ev(13'h0002);
        fork
            host.poll_idle(21'h080000, d);
            begin
                ev(13'h1000);
                ev(13'h0080);
                repeat (6) @(negedge clk);
                ev(13'h0200);
            end
        join
        chk(d, 16'h0090, "poll err");
        ev(13'h0004);
        host.rd_begin(21'h000000, d);
        ev(13'h1400);
        chk(dq_out, 16'h0080, "held");
        host.rd_end();
        rd(21'h000000);
        chk(d, 16'h0082, "refresh");
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(live_status, 8'h80, "hw reset");
        give_verdict();
    end
endmodule
`default_nettype wire
